/* File: core/dams_conv_chan.v */
// Purpose: one converter channel result sequencing
// Assumes: tick marks one filter output period
// Notes:   result takes two periods to settle after reset
`timescale 1ns/10ps
`default_nettype none
`include "dams_regs.vh"

module dams_conv_chan (
  // clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // control
  input  wire        restart,
  input  wire        run,
  input  wire        tick,
  input  wire [1:0]  align_outs,
  // result
  output reg         done
);

  // settle plus alignment reaches five periods, so three bits are needed
  reg  [2:0] wait_reg;

  always @(posedge mclk)
  begin
    if (!rstn || restart || !run)
    begin
      wait_reg <= {1'b0, `DAMS_SETTLE_OUTS} + {1'b0, align_outs};
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (tick)
      begin
        if (wait_reg <= 3'h1)
        begin
          done     <= 1'b1;
          wait_reg <= 3'h1;
        end
        else
          wait_reg <= wait_reg - 3'h1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/dams_rate_gen.v */
// Purpose: conversion period tick from the decimation factor
// Assumes: one tick per converter output period
// Notes:   period is factor modulator ticks times 24
`timescale 1ns/10ps
`default_nettype none
`include "dams_regs.vh"

module dams_rate_gen #(
  parameter MOD_DIV = 7629
)
(
  // clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // control
  input  wire        restart,
  input  wire        run,
  input  wire [7:0]  factor,
  // tick
  output reg         tick
);

  reg  [23:0] pre_reg;
  reg  [15:0] cnt_reg;
  wire [15:0] period;
  wire        mod_tick;

  assign period   = {8'h00, factor} * 16'd24;
  assign mod_tick = (pre_reg == 24'h000000);

  always @(posedge mclk)
  begin
    if (!rstn || restart || !run)
    begin
      pre_reg <= 24'h000000;
      cnt_reg <= 16'h0000;
      tick    <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (pre_reg == MOD_DIV[23:0] - 24'h000001)
        pre_reg <= 24'h000000;
      else
        pre_reg <= pre_reg + 24'h000001;
      if (mod_tick)
      begin
        if (cnt_reg >= period - 16'h0001)
        begin
          cnt_reg <= 16'h0000;
          tick    <= 1'b1;
        end
        else
          cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/dams_regs.vh */
// Purpose: constants for the dual converter mode sequencer
// Assumes: special function register addresses are 8 bits wide
// Notes:   definitions only
`ifndef DAMS_REGS_VH
`define DAMS_REGS_VH

// register addresses
`define DAMS_ADDR_STAT      8'hd8
`define DAMS_ADDR_MODE      8'hd1
`define DAMS_ADDR_CON0      8'hd2
`define DAMS_ADDR_CON1      8'hd3
`define DAMS_ADDR_SF        8'hd4

// reset values and maximum decimation factor
`define DAMS_CON0_RST       8'h07
`define DAMS_CON1_RST       8'h00
`define DAMS_MODE_RST       8'h00
`define DAMS_SF_RST         8'h45
`define DAMS_SF_MAX         8'hff

// mode register fields
`define DAMS_MODE_EN0       5
`define DAMS_MODE_EN1       4
`define DAMS_MODE_MD_HI     2
`define DAMS_MODE_MD_LO     0
`define DAMS_MODE_MASK      8'h37

// control register fields
`define DAMS_CON_XREF       6
`define DAMS_CON_CH_HI      5
`define DAMS_CON_CH_LO      4
`define DAMS_CON_UNI        3
`define DAMS_CON0_MASK      8'h7f
`define DAMS_CON1_MASK      8'h78

// status register fields
`define DAMS_STAT_PRIMARY_READY_FLAG      7
`define DAMS_STAT_AUX_READY_FLAG      6
`define DAMS_STAT_CAL       5
`define DAMS_STAT_ERR0      3
`define DAMS_STAT_AUX_ERROR_FLAG      2

// mode codes
`define DAMS_MD_PDOWN       3'h0
`define DAMS_MD_IDLE        3'h1
`define DAMS_MD_SINGLE      3'h2
`define DAMS_MD_CONT        3'h3
`define DAMS_MD_ZS_INT      3'h4
`define DAMS_MD_FS_INT      3'h5
`define DAMS_MD_ZS_SYS      3'h6
`define DAMS_MD_FS_SYS      3'h7

// channel codes
`define DAMS_CH0_SHORT      2'h2
`define DAMS_CH1_TEMP       2'h2

// input mux codes driven to the analog front end
`define DAMS_MUX_PINS       2'h0
`define DAMS_MUX_SHORT      2'h1
`define DAMS_MUX_REF        2'h2

// timing
`define DAMS_MCLK_PS        4000
`define DAMS_MOD_PS         30517578
`define DAMS_MOD_DIV        (`DAMS_MOD_PS / `DAMS_MCLK_PS)
`define DAMS_OUT_MOD        24
`define DAMS_SETTLE_OUTS    2'h2
`define DAMS_ALIGN_MAX      2'h3

// coding offsets
`define DAMS_BIPOLAR_OFS    24'h800000
`define DAMS_UNIPOLAR_OFS   24'h000000

`endif

/* File: core/dams_top.v */
// Purpose: mode sequencer for a primary and an auxiliary converter
// Assumes: core writes and reads registers through sfr_* in one cycle
// Notes:   analog front end controlled through mux and coding outputs
`timescale 1ns/10ps
`default_nettype none
`include "dams_regs.vh"

// Operation
// - continuous mode writes results at the decimation update rate while the ready flag is clear
// - internal zero-scale calibration shorts enabled converter inputs
// - internal full-scale calibration routes selected reference to input
// - system zero-scale calibration measures the channel-selected pins
// - system full-scale calibration measures the channel-selected pins
// - a mode field write changing value resets both converters
// - a mode field write keeping value also resets both converters
// - primary control write while enabled, or enable rise, resets both
// - auxiliary control write resets only auxiliary; enable rise is a mode write and resets both
// - primary keeps converting undisturbed through auxiliary resets
// - auxiliary aligns to primary outputs, up to three periods late
// - calibration code write clears both ready flags then starts
// - calibration end writes cal registers, flags, mode field to 000
// - auxiliary calibration with temperature sensor selected fails
// - failed calibration sets aux ready and error, keeps cal registers
// - calibrations always use maximum decimation factor
// - primary control bit 6 picks external or internal reference
// - primary control at D2H, resets to 07H
// - single conversion updates results and flags then mode to 000
// - primary results blocked while its ready flag is set
// - primary control bit 3 picks unipolar or bipolar coding
module dams_top #(
  parameter MOD_DIV = `DAMS_MOD_DIV
)
(
  // clock and reset
  input  wire        mclk,
  input  wire        rstn,
  // special function register port
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_addr,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  // converter data from the analog filters
  input  wire [23:0] conv0_data,
  input  wire [15:0] conv1_data,
  // analog front end control
  output reg         pwr0_on,
  output reg         pwr1_on,
  output reg  [1:0]  mux0_sel,
  output reg  [1:0]  mux1_sel,
  output reg         extref0_on,
  output reg         extref1_on,
  output reg  [23:0] code0_offset,
  output reg  [7:0]  dec_factor,
  // results
  output reg  [23:0] result0_reg,
  output reg  [15:0] result1_reg,
  output reg  [23:0] cal0_zero_reg,
  output reg  [23:0] cal0_full_reg,
  output reg  [15:0] cal1_zero_reg,
  output reg  [15:0] cal1_full_reg,
  output reg         cal_write_pulse
);

  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_DONE = 2'h2;

  reg  [7:0] converter_mode_reg;
  reg  [7:0] primary_adc_control;
  reg  [7:0] aux_converter_control;
  reg  [7:0] decimation_factor_reg;
  reg        primary_ready_flag;
  reg        aux_ready_flag;
  reg        cal_flag_reg;
  reg        primary_error_flag;
  reg        aux_error_flag;
  reg  [1:0] state_reg;
  reg        got0_reg;
  reg        got1_reg;

  wire [2:0] op_mode_field;
  wire       primary_enable_bit;
  wire       aux_enable_bit;
  wire       wr_mode;
  wire       wr_con0;
  wire       wr_con1;
  wire       wr_sf;
  wire       wr_stat;
  wire [7:0] new_mode;
  wire       rst_both;
  wire       rst_aux;
  wire       is_cal_code;
  wire       active0;
  wire       active1;
  wire       tick;
  wire       done0;
  wire       done1;
  wire       aux_temp_sel;
  wire [1:0] align_outs;
  wire       conv_mode;
  wire [7:0] stat_value;

  assign op_mode_field      = converter_mode_reg[`DAMS_MODE_MD_HI:`DAMS_MODE_MD_LO];
  assign primary_enable_bit = converter_mode_reg[`DAMS_MODE_EN0];
  assign aux_enable_bit     = converter_mode_reg[`DAMS_MODE_EN1];
  assign wr_mode = sfr_wr && (sfr_addr == `DAMS_ADDR_MODE);
  assign wr_con0 = sfr_wr && (sfr_addr == `DAMS_ADDR_CON0);
  assign wr_con1 = sfr_wr && (sfr_addr == `DAMS_ADDR_CON1);
  assign wr_sf   = sfr_wr && (sfr_addr == `DAMS_ADDR_SF);
  assign wr_stat = sfr_wr && (sfr_addr == `DAMS_ADDR_STAT);
  assign new_mode = sfr_wdata & `DAMS_MODE_MASK;

  // any mode write resets both, value change or not
  assign rst_both = wr_mode
                  || (wr_con0 && primary_enable_bit)
                  || (wr_mode && new_mode[`DAMS_MODE_EN0] && !primary_enable_bit);
  // aux-only reset leaves the primary chain untouched
  assign rst_aux  = wr_con1
                  || (wr_mode && new_mode[`DAMS_MODE_EN1] && !aux_enable_bit);

  assign is_cal_code = op_mode_field[2];
  assign conv_mode   = (op_mode_field == `DAMS_MD_CONT) || (op_mode_field == `DAMS_MD_SINGLE);
  assign active0 = primary_enable_bit && (conv_mode || is_cal_code);
  assign active1 = aux_enable_bit && (conv_mode || is_cal_code);
  assign aux_temp_sel =
    (aux_converter_control[`DAMS_CON_CH_HI:`DAMS_CON_CH_LO] == `DAMS_CH1_TEMP);
  // aux falls into step with primary outputs when primary is running
  assign align_outs = active0 ? `DAMS_ALIGN_MAX : 2'h0;

  assign stat_value = {primary_ready_flag, aux_ready_flag, cal_flag_reg, 1'b0,
                       primary_error_flag, aux_error_flag, 2'b00};

  // shared rate generator; primary resets restart it, aux resets do not
  dams_rate_gen #(
    .MOD_DIV (MOD_DIV)
  ) u_rate (
    .mclk    (mclk),
    .rstn    (rstn),
    .restart (rst_both),
    .run     (active0 || active1),
    .factor  (dec_factor),
    .tick    (tick)
  );

  dams_conv_chan u_chan0 (
    .mclk       (mclk),
    .rstn       (rstn),
    .restart    (rst_both),
    .run        (active0),
    .tick       (tick),
    .align_outs (2'h0),
    .done       (done0)
  );

  dams_conv_chan u_chan1 (
    .mclk       (mclk),
    .rstn       (rstn),
    .restart    (rst_both || rst_aux),
    .run        (active1),
    .tick       (tick),
    .align_outs (align_outs),
    .done       (done1)
  );

  // register writes and sequencing
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      converter_mode_reg    <= `DAMS_MODE_RST;
      primary_adc_control   <= `DAMS_CON0_RST;
      aux_converter_control <= `DAMS_CON1_RST;
      decimation_factor_reg <= `DAMS_SF_RST;
      primary_ready_flag    <= 1'b0;
      aux_ready_flag        <= 1'b0;
      cal_flag_reg          <= 1'b0;
      primary_error_flag    <= 1'b0;
      aux_error_flag        <= 1'b0;
      state_reg             <= ST_IDLE;
      got0_reg              <= 1'b0;
      got1_reg              <= 1'b0;
      result0_reg           <= 24'h000000;
      result1_reg           <= 16'h0000;
      cal0_zero_reg         <= 24'h000000;
      cal0_full_reg         <= 24'h000000;
      cal1_zero_reg         <= 16'h0000;
      cal1_full_reg         <= 16'h0000;
      cal_write_pulse       <= 1'b0;
    end
    else
    begin
      cal_write_pulse <= 1'b0;
      if (wr_con0)
        primary_adc_control <= sfr_wdata & `DAMS_CON0_MASK;
      if (wr_con1)
        aux_converter_control <= sfr_wdata & `DAMS_CON1_MASK;
      // rate is locked while a converter is active
      if (wr_sf && !(active0 || active1))
        decimation_factor_reg <= sfr_wdata;
      if (wr_stat)
      begin
        primary_ready_flag <= sfr_wdata[`DAMS_STAT_PRIMARY_READY_FLAG];
        aux_ready_flag     <= sfr_wdata[`DAMS_STAT_AUX_READY_FLAG];
      end
      if (wr_mode)
      begin
        converter_mode_reg <= new_mode;
        state_reg          <= ST_RUN;
        got0_reg           <= 1'b0;
        got1_reg           <= 1'b0;
        cal_flag_reg       <= 1'b0;
        primary_error_flag <= 1'b0;
        aux_error_flag     <= 1'b0;
        if (new_mode[2])
        begin
          primary_ready_flag <= 1'b0;
          aux_ready_flag     <= 1'b0;
        end
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
            state_reg <= ST_IDLE;
          ST_RUN:
          begin
            if (done0 && active0 && !got0_reg)
            begin
              if (is_cal_code)
              begin
                got0_reg           <= 1'b1;
                primary_ready_flag <= 1'b1;
                cal_write_pulse    <= 1'b1;
                if (!op_mode_field[0])
                  cal0_zero_reg <= conv0_data;
                else
                  cal0_full_reg <= conv0_data;
              end
              else if (!primary_ready_flag)
              begin
                result0_reg        <= conv0_data;
                primary_ready_flag <= 1'b1;
                got0_reg           <= (op_mode_field == `DAMS_MD_SINGLE);
              end
            end
            if (done1 && active1 && !got1_reg)
            begin
              if (is_cal_code)
              begin
                got1_reg       <= 1'b1;
                aux_ready_flag <= 1'b1;
                if (aux_temp_sel)
                  aux_error_flag <= 1'b1;
                else
                begin
                  cal_write_pulse <= 1'b1;
                  if (!op_mode_field[0])
                    cal1_zero_reg <= conv1_data;
                  else
                    cal1_full_reg <= conv1_data;
                end
              end
              else if (!aux_ready_flag)
              begin
                result1_reg    <= conv1_data;
                aux_ready_flag <= 1'b1;
                got1_reg       <= (op_mode_field == `DAMS_MD_SINGLE);
              end
            end
            if ((is_cal_code || op_mode_field == `DAMS_MD_SINGLE)
                && (got0_reg || !active0) && (got1_reg || !active1)
                && (active0 || active1))
              state_reg <= ST_DONE;
          end
          ST_DONE:
          begin
            // back to power-down once every enabled channel finished
            if (is_cal_code)
              cal_flag_reg <= 1'b1;
            converter_mode_reg[`DAMS_MODE_MD_HI:`DAMS_MODE_MD_LO] <= `DAMS_MD_PDOWN;
            state_reg <= ST_IDLE;
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // analog front end steering, registered
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      pwr0_on      <= 1'b0;
      pwr1_on      <= 1'b0;
      mux0_sel     <= `DAMS_MUX_PINS;
      mux1_sel     <= `DAMS_MUX_PINS;
      extref0_on   <= 1'b0;
      extref1_on   <= 1'b0;
      code0_offset <= `DAMS_BIPOLAR_OFS;
      dec_factor   <= `DAMS_SF_RST;
      sfr_rdata    <= 8'h00;
    end
    else
    begin
      pwr0_on <= active0;
      pwr1_on <= active1;
      extref0_on <= primary_adc_control[`DAMS_CON_XREF];
      extref1_on <= aux_converter_control[`DAMS_CON_XREF];
      code0_offset <= primary_adc_control[`DAMS_CON_UNI] ?
                      `DAMS_UNIPOLAR_OFS : `DAMS_BIPOLAR_OFS;
      dec_factor <= is_cal_code ? `DAMS_SF_MAX : decimation_factor_reg;
      case (op_mode_field)
        `DAMS_MD_ZS_INT:
        begin
          mux0_sel <= `DAMS_MUX_SHORT;
          mux1_sel <= `DAMS_MUX_SHORT;
        end
        `DAMS_MD_FS_INT:
        begin
          mux0_sel <= `DAMS_MUX_REF;
          mux1_sel <= `DAMS_MUX_REF;
        end
        default:
        begin
          // system cal and conversions use the channel-selected pins
          mux0_sel <= (primary_adc_control[`DAMS_CON_CH_HI:`DAMS_CON_CH_LO]
                       == `DAMS_CH0_SHORT) ? `DAMS_MUX_SHORT : `DAMS_MUX_PINS;
          mux1_sel <= `DAMS_MUX_PINS;
        end
      endcase
      case (sfr_addr)
        `DAMS_ADDR_STAT: sfr_rdata <= stat_value;
        `DAMS_ADDR_MODE: sfr_rdata <= converter_mode_reg;
        `DAMS_ADDR_CON0: sfr_rdata <= primary_adc_control;
        `DAMS_ADDR_CON1: sfr_rdata <= aux_converter_control;
        `DAMS_ADDR_SF:   sfr_rdata <= decimation_factor_reg;
        default:         sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: dv/dams_cpu_model.sv */
// Purpose: processor core side of the register port
// Assumes: one-cycle write strobe, read data one cycle after address
// Notes:   released lines never keep the last value
`timescale 1ns/10ps
`default_nettype none
module dams_cpu_model (
  // clock
  input  wire logic       mclk,
  // register port
  output var logic        sfr_wr,
  output var logic        sfr_rd,
  output var logic [7:0]  sfr_addr,
  output var logic [7:0]  sfr_wdata,
  input  wire logic [7:0] sfr_rdata
);
  initial
  begin
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
  end
  task wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge mclk);
    #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = w;
    @(posedge mclk);
    #1;
    sfr_wr = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = ~w;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge mclk);
    #1;
    d = sfr_rdata;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
  endtask
endmodule
`default_nettype wire

/* File: dv/dams_top_sva.sv */
// Purpose: port assertions for the mode sequencer
// Assumes: one clock, rstn synchronous active low
// Notes:   bound into dams_top
`timescale 1ns/10ps
`default_nettype none
module dams_top_sva #(
  parameter MOD_DIV = 2
)
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // register port
  input wire logic        sfr_wr,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  // front end
  input wire logic        pwr0_on,
  input wire logic        pwr1_on,
  input wire logic [1:0]  mux0_sel,
  input wire logic [1:0]  mux1_sel,
  input wire logic        extref0_on,
  input wire logic [23:0] code0_offset,
  input wire logic [7:0]  dec_factor,
  input wire logic        cal_write_pulse
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  wire md_wr  = sfr_wr && sfr_addr == 8'hd1;
  wire con_wr = sfr_wr && sfr_addr == 8'hd2;
  a_cal_max_dec:
    assert property (md_wr && sfr_wdata[5] && sfr_wdata[2] |-> ##[1:3] dec_factor == 8'hff)
    else $error("calibration not at maximum decimation");
  a_zero_short:
    assert property (md_wr && sfr_wdata[5] && sfr_wdata[2:0] == 3'h4 |-> ##[1:3] mux0_sel == 2'h1)
    else $error("internal zero calibration not shorted");
  a_aux_short:
    assert property (md_wr && sfr_wdata[4] && sfr_wdata[2:0] == 3'h4 |-> ##[1:3] mux1_sel == 2'h1)
    else $error("internal zero calibration aux not shorted");
  a_full_ref:
    assert property (md_wr && sfr_wdata[5] && sfr_wdata[2:0] == 3'h5 |-> ##[1:3] mux0_sel == 2'h2)
    else $error("internal full calibration not on reference");
  a_sys_no_ref:
    assert property (md_wr && sfr_wdata[5] && sfr_wdata[2:1] == 2'b11 |-> ##[1:3] mux0_sel != 2'h2)
    else $error("system calibration routed to reference");
  a_disabled_off:
    assert property (md_wr && !sfr_wdata[5] |-> ##[1:3] !pwr0_on)
    else $error("disabled primary stays powered");
  a_unipolar:
    assert property (con_wr && sfr_wdata[3] |-> ##[1:3] code0_offset == 24'h000000)
    else $error("unipolar coding offset wrong");
  a_ext_ref:
    assert property (con_wr && sfr_wdata[6] |-> ##[1:3] extref0_on)
    else $error("external reference not selected");
  a_pulse_single:
    assert property (cal_write_pulse |=> !cal_write_pulse)
    else $error("calibration write pulse too long");
  a_cal_done_off:
    assert property (cal_write_pulse && !pwr1_on |-> ##[1:6] !pwr0_on)
    else $error("no power-down after calibration");
  a_reset_vals:
    assert property ($rose(rstn) |-> code0_offset == 24'h800000 && dec_factor == 8'h45 && !pwr0_on)
    else $error("reset values wrong");
endmodule
bind dams_top dams_top_sva #(.MOD_DIV(MOD_DIV)) u_sva (
  .mclk(mclk), .rstn(rstn), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .pwr0_on(pwr0_on), .pwr1_on(pwr1_on), .mux0_sel(mux0_sel), .mux1_sel(mux1_sel),
  .extref0_on(extref0_on),
  .code0_offset(code0_offset), .dec_factor(dec_factor), .cal_write_pulse(cal_write_pulse));
`default_nettype wire

/* File: dv/dams_top_tb.sv */
// Purpose: self-checking bench for the mode sequencer
// Assumes: MOD_DIV of 2 and decimation 0d keep periods short
// Notes:   register rows first, sequencing by hand after
`timescale 1ns/10ps
`default_nettype none
module dams_top_tb;
  localparam int PER = 13 * 24 * 2;
  localparam int CAL = 255 * 24 * 2;
  logic        mclk = 1'b0;
  logic        rstn;
  logic [23:0] conv0_data;
  logic [15:0] conv1_data;
  wire         sfr_wr;
  wire         sfr_rd;
  wire  [7:0]  sfr_addr;
  wire  [7:0]  sfr_wdata;
  wire  [7:0]  sfr_rdata;
  wire         pwr0_on;
  wire         pwr1_on;
  wire  [1:0]  mux0_sel;
  wire  [7:0]  dec_factor;
  wire  [23:0] result0_reg;
  wire  [15:0] result1_reg;
  wire  [23:0] cal0_zero_reg;
  wire  [15:0] cal1_zero_reg;
  wire         cal_write_pulse;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          n_pulse = 0;
  logic [7:0]  d;
  logic [15:0] z;
  bit          ok;
  // address, write data, expected readback
  logic [23:0] rows [5] = '{24'hd2ff7f, 24'hd20707, 24'hd3ff78, 24'hd40d0d, 24'hd55a00};
  logic [1:0]  exp_mux [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
  always #2 mclk = ~mclk;
  always @(posedge mclk)
    if (cal_write_pulse === 1'b1)
      n_pulse++;
  dams_cpu_model cpu (.mclk(mclk), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  dams_top #(.MOD_DIV(2)) dut (.mclk(mclk), .rstn(rstn), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .conv0_data(conv0_data), .conv1_data(conv1_data), .pwr0_on(pwr0_on), .pwr1_on(pwr1_on),
    .mux0_sel(mux0_sel), .mux1_sel(), .extref0_on(), .extref1_on(), .code0_offset(),
    .dec_factor(dec_factor), .result0_reg(result0_reg), .result1_reg(result1_reg),
    .cal0_zero_reg(cal0_zero_reg), .cal0_full_reg(), .cal1_zero_reg(cal1_zero_reg),
    .cal1_full_reg(), .cal_write_pulse(cal_write_pulse));
  task chk(input bit c, input string m);
    n_checks++;
    if (!c)
    begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task wrap_up();
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // sel 0 primary result, 1 aux result, 2 calibration write
  task wait_hit(input int sel, input int lim, output bit hit);
    hit = 0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      @(posedge mclk);
      #1;
      hit = sel == 0 ? result0_reg === conv0_data :
            sel == 1 ? result1_reg === conv1_data : n_pulse > 0;
    end
  endtask
  // flags cleared only after the write: an early tick would otherwise block the result
  task restart(input logic [7:0] a, input logic [7:0] w);
    cpu.wr(a, w);
    cpu.wr(8'hd8, 8'h00);
    conv0_data = conv0_data + 24'h1;
    repeat (PER + PER / 2) @(posedge mclk);
    #1;
    chk(result0_reg !== conv0_data, "result without restart");
    wait_hit(0, PER, ok);
    chk(ok, "no result after restart");
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    rstn = 1'b0;
    conv0_data = 24'h123456;
    conv1_data = 16'h1234;
    repeat (20) @(posedge mclk);
    #1;
    rstn = 1'b1;
    cpu.rd(8'hd2, d);
    chk(d === 8'h07, "control reset value");
    foreach (rows[i])
    begin
      cpu.wr(rows[i][23:16], rows[i][15:8]);
      cpu.rd(rows[i][23:16], d);
      chk(d === rows[i][7:0], "register readback");
    end
    cpu.wr(8'hd1, 8'h23);
    wait_hit(0, 2 * PER + 20, ok);
    chk(ok, "no continuous result");
    conv0_data = 24'h00abcd;
    repeat (PER + 20) @(posedge mclk);
    #1;
    chk(result0_reg === 24'h123456, "result written while ready");
    cpu.wr(8'hd8, 8'h00);
    wait_hit(0, PER + 20, ok);
    chk(ok, "continuous update missing");
    restart(8'hd1, 8'h23);
    restart(8'hd2, 8'h27);
    chk(mux0_sel === 2'h1, "input short not selected");
    cpu.wr(8'hd1, 8'h22);
    restart(8'hd1, 8'h33);
    conv0_data = conv0_data + 24'h1;
    conv1_data = 16'h5a5a;
    cpu.wr(8'hd3, 8'h00);
    cpu.wr(8'hd8, 8'h00);
    wait_hit(0, PER + 20, ok);
    chk(ok, "primary disturbed by aux reset");
    chk(result1_reg !== conv1_data, "aux result early");
    wait_hit(1, 6 * PER, ok);
    chk(ok, "aux result late");
    cpu.wr(8'hd1, 8'h00);
    cpu.wr(8'hd8, 8'h00);
    conv0_data = 24'h00beef;
    cpu.wr(8'hd1, 8'h22);
    wait_hit(0, 2 * PER + 20, ok);
    repeat (8) @(posedge mclk);
    cpu.rd(8'hd1, d);
    chk(ok && d[2:0] === 3'h0, "single conversion end");
    cpu.wr(8'hd2, 8'h07);
    cpu.wr(8'hd1, 8'h24);
    cpu.rd(8'hd8, d);
    chk(d[7:6] === 2'b00, "ready flags kept");
    for (int c = 4; c < 8; c++)
    begin
      cpu.wr(8'hd1, 8'h20 | c[7:0]);
      repeat (3) @(posedge mclk);
      #1;
      chk(mux0_sel === exp_mux[c - 4], "calibration routing");
      chk(dec_factor === 8'hff, "calibration decimation");
    end
    conv0_data = 24'h0a0b0c;
    n_pulse = 0;
    cpu.wr(8'hd1, 8'h24);
    wait_hit(2, 2 * CAL + 200, ok);
    chk(ok && cal0_zero_reg === 24'h0a0b0c, "zero calibration result");
    repeat (8) @(posedge mclk);
    cpu.rd(8'hd1, d);
    chk(d[2:0] === 3'h0, "mode not back to power-down");
    cpu.rd(8'hd8, d);
    chk(d[5] === 1'b1, "calibration flag missing");
    cpu.wr(8'hd3, 8'h20);
    z = cal1_zero_reg;
    n_pulse = 0;
    cpu.wr(8'hd1, 8'h14);
    repeat (3) @(posedge mclk);
    #1;
    chk(pwr0_on === 1'b0, "disabled primary powered");
    ok = 0;
    for (int i = 0; i < CAL + 1500 && !ok; i++)
    begin
      cpu.rd(8'hd8, d);
      ok = d[6];
    end
    chk(ok && d[2] === 1'b1, "aux failure flags");
    chk(cal1_zero_reg === z && n_pulse == 0, "failed calibration wrote");
    wrap_up();
  end
endmodule
`default_nettype wire
